// file: rtl/plrs_defs.svh
/*
  Constants for the link request and status block: line codes, request
  type codes, request stream bit positions, status layout and reset values.
  Assumes it is included by bare name from files that need the figures.
*/
`ifndef PLRS_DEFS_SVH
`define PLRS_DEFS_SVH

// ==========================================================================
// Control pair codes
// ==========================================================================
`define PLRS_CTL_IDLE      2'h0
`define PLRS_CTL_STATUS    2'h1
`define PLRS_CTL_RECEIVE   2'h2
`define PLRS_CTL_GRANT     2'h3
`define PLRS_LNK_RELEASE   2'h0

// ==========================================================================
// Request type codes
// ==========================================================================
`define PLRS_REQ_IMM       3'h0
`define PLRS_REQ_ISO       3'h1
`define PLRS_REQ_PRI       3'h2
`define PLRS_REQ_FAIR      3'h3
`define PLRS_REQ_READ      3'h4
`define PLRS_REQ_WRITE     3'h5
`define PLRS_REQ_ACCEL     3'h6
`define PLRS_REQ_RESERVED  3'h7

// ==========================================================================
// Index of the first sampled bit, the last type bit and the last bit of each request stream
// ==========================================================================
`define PLRS_IDX_FIRST     5'h01
`define PLRS_IDX_TYPE      5'h03
`define PLRS_IDX_BUS       5'h06
`define PLRS_IDX_READ      5'h08
`define PLRS_IDX_WRITE     5'h10
`define PLRS_IDX_ACCEL     5'h05

// ==========================================================================
// Field positions in the request shift register
// ==========================================================================
`define PLRS_RD_ADDR       3:0
`define PLRS_WR_ADDR       11:8
`define PLRS_WR_DATA       7:0
`define PLRS_ACCEL_CTRL    0

// ==========================================================================
// Register file and status transfer
// ==========================================================================
`define PLRS_REG_RESET     8'h00
`define PLRS_ACCEL_REG     4'h5
`define PLRS_ACCEL_BIT     1
`define PLRS_NODE_ID_REG   4'h0
`define PLRS_ST_LAST_SHORT 3'h1
`define PLRS_ST_LAST_LONG  3'h7
`define PLRS_BUF_DEPTH     2

`endif

// file: rtl/plrs_pkg.sv
/*
  Types shared by the link request and status block.
  Assumes the constants header is compiled alongside.
*/
package plrs_pkg;

  // ========================================================================
  // State, request and status entry types
  // ========================================================================
  typedef enum logic [2:0] {
    PLRS_IF_IDLE    = 3'h0,
    PLRS_IF_STATUS  = 3'h1,
    PLRS_IF_RECEIVE = 3'h2,
    PLRS_IF_GRANT   = 3'h3,
    PLRS_IF_LINK    = 3'h4
  } plrs_if_state_e;

  typedef enum logic {
    PLRS_DEC_WAIT  = 1'b0,
    PLRS_DEC_SHIFT = 1'b1
  } plrs_dec_state_e;

  typedef logic [2:0]  plrs_req_t;
  typedef logic [12:0] plrs_status_entry_t;

endpackage

// file: rtl/plrs_pair_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "plrs_defs.svh"

module plrs_pair_buffer
  import plrs_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = `PLRS_BUF_DEPTH
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] store_ff [DEPTH];
  logic [PW-1:0]    wrPtr_ff;
  logic [PW-1:0]    rdPtr_ff;
  logic [PW:0]      count_ff;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count_ff != FULL);
  assign outValid = (count_ff != '0);
  assign outData  = store_ff[rdPtr_ff];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (doPush)
    begin
      store_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_ff <= bump(wrPtr_ff);
      end
      if (doPop)
      begin
        rdPtr_ff <= bump(rdPtr_ff);
      end
      if (doPush && !doPop)
      begin
        count_ff <= count_ff + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

// file: rtl/plrs_top.sv
/*
  Device end of the link controller interface: decodes serial requests on
  the request line, keeps pending request state, applies register writes,
  steers acceleration and sends status transfers on the data lines under the status code on the control pair.
  Assumes the link controller runs on ref_clk and that arbitration, packet
  reception and status events come from the device core as level and
  pulse inputs.
*/
`timescale 1ns/1ps
`include "plrs_defs.svh"

module plrs_top
  import plrs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       linkRequestLine,
  input  wire logic [1:0] controlPairIn,
  output logic      [1:0] controlPairOut,
  output logic            controlPairOe,
  output logic      [1:0] statusDataOut,
  output logic            statusDataOe,
  input  wire logic       packetReceiveActive,
  input  wire logic       arbitrationWon,
  input  wire logic       arbResetGapEvent,
  input  wire logic       subactionGapEvent,
  input  wire logic       busResetEvent,
  input  wire logic       interruptEvent,
  input  wire logic       selfIdComplete,
  output logic            busRequestPending,
  output logic      [2:0] busRequestKind,
  output logic      [2:0] busRequestSpeed,
  output logic            accelFeaturesOn,
  output logic            regWriteStrobe,
  output logic      [3:0] regWriteAddr,
  output logic      [7:0] regWriteData,
  output logic            readPending
);

  // ========================================================================
  // Declarations
  // ========================================================================
  plrs_dec_state_e    decState_ff;
  logic [4:0]         bitIdx_ff;
  logic [15:0]        shift_ff;
  plrs_req_t          reqType_ff;
  logic               rxDuring_ff;
  logic [15:0]        nxtShift;
  logic               inShift;
  logic               lastBit;
  logic               reservedEnd;
  logic               stopOk;
  logic               reqDone;

  plrs_if_state_e     state_ff;
  plrs_if_state_e     nxtState;
  logic [2:0]         stCnt_ff;
  logic [2:0]         nxtCnt;
  logic               stLong_ff;
  logic               nxtLong;
  logic               grantTaken;
  logic               regDelivered;

  logic               busReqPending_ff;
  plrs_req_t          busReqKind_ff;
  logic [2:0]         busReqSpeed_ff;
  logic               acceleration_control_request_ff;
  logic [7:0]         regs_ff [16];
  logic [3:0]         flag_ff;
  logic               readPending_ff;
  logic               readWait_ff;
  logic [3:0]         readAddr_ff;
  logic               selfIdWait_ff;

  logic               bufInValid;
  logic               bufInReady;
  plrs_status_entry_t bufInData;
  logic               bufOutValid;
  plrs_status_entry_t bufOutData;
  logic [15:0]        stWord;

  logic [1:0]         controlPairOut_ff;
  logic               controlPairOe_ff;
  logic [1:0]         statusDataOut_ff;
  logic               statusDataOe_ff;
  logic               accelFeaturesOn_ff;
  logic               regWriteStrobe_ff;
  logic [3:0]         regWriteAddr_ff;
  logic [7:0]         regWriteData_ff;

  // ========================================================================
  // Helpers
  // ========================================================================
  function automatic logic isBusReq(input plrs_req_t t);
    isBusReq = (t[2] == 1'b0);
  endfunction

  function automatic logic isFairPri(input plrs_req_t t);
    isFairPri = (t == `PLRS_REQ_PRI) || (t == `PLRS_REQ_FAIR);
  endfunction

  function automatic logic [4:0] lastIndex(input plrs_req_t t);
    unique case (t)
      `PLRS_REQ_READ:  lastIndex = `PLRS_IDX_READ;
      `PLRS_REQ_WRITE: lastIndex = `PLRS_IDX_WRITE;
      `PLRS_REQ_ACCEL: lastIndex = `PLRS_IDX_ACCEL;
      default:         lastIndex = `PLRS_IDX_BUS;
    endcase
  endfunction

  function automatic logic [1:0] ctlCode(input plrs_if_state_e s);
    unique case (s)
      PLRS_IF_STATUS:  ctlCode = `PLRS_CTL_STATUS;
      PLRS_IF_RECEIVE: ctlCode = `PLRS_CTL_RECEIVE;
      PLRS_IF_GRANT:   ctlCode = `PLRS_CTL_GRANT;
      default:         ctlCode = `PLRS_CTL_IDLE;
    endcase
  endfunction

  // ========================================================================
  // Request stream decoder
  // ========================================================================
  // Bits arrive first to last; each sample shifts in at the low end.
  assign nxtShift    = {shift_ff[14:0], linkRequestLine};
  assign inShift     = (decState_ff == PLRS_DEC_SHIFT);
  assign reservedEnd = inShift && (bitIdx_ff == `PLRS_IDX_TYPE) &&
                       (nxtShift[2:0] == `PLRS_REQ_RESERVED);
  assign lastBit     = inShift && (bitIdx_ff > `PLRS_IDX_TYPE) &&
                       (bitIdx_ff == lastIndex(reqType_ff));
  // A bus request ends on its speed field because its stop bit is optional.
  assign stopOk      = isBusReq(reqType_ff) || !linkRequestLine;
  assign reqDone     = lastBit && stopOk;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      decState_ff <= PLRS_DEC_WAIT;
      bitIdx_ff   <= '0;
      shift_ff    <= '0;
      reqType_ff  <= `PLRS_REQ_IMM;
      rxDuring_ff <= 1'b0;
    end
    else
    begin
      unique case (decState_ff)
        PLRS_DEC_WAIT:
        begin
          shift_ff    <= '0;
          bitIdx_ff   <= `PLRS_IDX_FIRST;
          rxDuring_ff <= (state_ff == PLRS_IF_RECEIVE);
          if (linkRequestLine)
          begin
            decState_ff <= PLRS_DEC_SHIFT;
          end
        end
        PLRS_DEC_SHIFT:
        begin
          shift_ff  <= nxtShift;
          bitIdx_ff <= bitIdx_ff + 1'b1;
          if (state_ff == PLRS_IF_RECEIVE)
          begin
            rxDuring_ff <= 1'b1;
          end
          if (bitIdx_ff == `PLRS_IDX_TYPE)
          begin
            reqType_ff <= nxtShift[2:0];
          end
          if (lastBit || reservedEnd)
          begin
            decState_ff <= PLRS_DEC_WAIT;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Bus request pending state
  // ========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busReqPending_ff <= 1'b0;
      busReqKind_ff    <= `PLRS_REQ_IMM;
      busReqSpeed_ff   <= '0;
    end
    else if (busResetEvent)
    begin
      busReqPending_ff <= 1'b0;
    end
    else if (busReqPending_ff)
    begin
      if (grantTaken)
      begin
        busReqPending_ff <= 1'b0;
      end
      else if ((state_ff == PLRS_IF_RECEIVE) && isFairPri(busReqKind_ff))
      begin
        busReqPending_ff <= 1'b0;
      end
    end
    else if (reqDone && isBusReq(reqType_ff))
    begin
      if (!(isFairPri(reqType_ff) && (rxDuring_ff || state_ff == PLRS_IF_RECEIVE)))
      begin
        busReqPending_ff <= 1'b1;
        busReqKind_ff    <= reqType_ff;
        busReqSpeed_ff   <= nxtShift[2:0];
      end
    end
  end

  // ========================================================================
  // Register file and acceleration control
  // ========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
      begin
        regs_ff[i] <= `PLRS_REG_RESET;
      end
    end
    else if (reqDone && (reqType_ff == `PLRS_REQ_WRITE))
    begin
      regs_ff[shift_ff[`PLRS_WR_ADDR]] <= shift_ff[`PLRS_WR_DATA];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      regWriteStrobe_ff <= 1'b0;
      regWriteAddr_ff   <= '0;
      regWriteData_ff   <= '0;
    end
    else
    begin
      regWriteStrobe_ff <= reqDone && (reqType_ff == `PLRS_REQ_WRITE);
      if (reqDone && (reqType_ff == `PLRS_REQ_WRITE))
      begin
        regWriteAddr_ff <= shift_ff[`PLRS_WR_ADDR];
        regWriteData_ff <= shift_ff[`PLRS_WR_DATA];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acceleration_control_request_ff        <= 1'b1;
      accelFeaturesOn_ff <= 1'b0;
    end
    else
    begin
      if (busResetEvent || (reqDone && reqType_ff == `PLRS_REQ_ISO && !busReqPending_ff))
      begin
        acceleration_control_request_ff <= 1'b1;
      end
      else if (reqDone && (reqType_ff == `PLRS_REQ_ACCEL))
      begin
        acceleration_control_request_ff <= shift_ff[`PLRS_ACCEL_CTRL];
      end
      accelFeaturesOn_ff <= regs_ff[`PLRS_ACCEL_REG][`PLRS_ACCEL_BIT] && acceleration_control_request_ff;
    end
  end

  // ========================================================================
  // Register read results and self-identity node address
  // ========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      readPending_ff <= 1'b0;
      readWait_ff    <= 1'b0;
      readAddr_ff    <= '0;
      selfIdWait_ff  <= 1'b0;
    end
    else
    begin
      // Bus reset deliberately leaves the pending read alone.
      if (reqDone && (reqType_ff == `PLRS_REQ_READ) && !readPending_ff)
      begin
        readPending_ff <= 1'b1;
        readWait_ff    <= 1'b1;
        readAddr_ff    <= shift_ff[`PLRS_RD_ADDR];
      end
      else
      begin
        if (readWait_ff && bufInReady)
        begin
          readWait_ff <= 1'b0;
        end
        if (regDelivered && bufOutData[12])
        begin
          readPending_ff <= 1'b0;
        end
      end
      if (selfIdComplete)
      begin
        selfIdWait_ff <= 1'b1;
      end
      else if (selfIdWait_ff && !readWait_ff && bufInReady)
      begin
        selfIdWait_ff <= 1'b0;
      end
    end
  end

  // Entry: read marker, register address, register contents.
  assign bufInValid = readWait_ff || selfIdWait_ff;
  assign bufInData  = readWait_ff ? {1'b1, readAddr_ff, regs_ff[readAddr_ff]}
                                  : {1'b0, `PLRS_NODE_ID_REG, regs_ff[`PLRS_NODE_ID_REG]};

  plrs_pair_buffer #(
    .WIDTH ($bits(plrs_status_entry_t)),
    .DEPTH (`PLRS_BUF_DEPTH)
  ) u_status_buffer (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (regDelivered),
    .outData  (bufOutData)
  );

  // ========================================================================
  // Status flags
  // ========================================================================
  // Word bit 0 sits at the top so that each cycle sends the next two bits.
  assign stWord = {flag_ff[0], flag_ff[1], flag_ff[2], flag_ff[3], bufOutData[11:0]};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flag_ff <= '0;
    end
    else
    begin
      // A flag counts as delivered once placed on the data lines; a new event wins.
      for (int i = 0; i < 4; i++)
      begin
        if ((nxtState == PLRS_IF_STATUS) && (nxtCnt == 3'(i / 2)))
        begin
          flag_ff[i] <= 1'b0;
        end
      end
      if (arbResetGapEvent)  flag_ff[0] <= 1'b1;
      if (subactionGapEvent) flag_ff[1] <= 1'b1;
      if (busResetEvent)     flag_ff[2] <= 1'b1;
      if (interruptEvent)    flag_ff[3] <= 1'b1;
    end
  end

  // ========================================================================
  // Interface control state
  // ========================================================================
  always_comb
  begin
    nxtState     = state_ff;
    nxtCnt       = stCnt_ff;
    nxtLong      = stLong_ff;
    grantTaken   = 1'b0;
    regDelivered = 1'b0;
    unique case (state_ff)
      PLRS_IF_IDLE:
      begin
        if (packetReceiveActive)
        begin
          nxtState = PLRS_IF_RECEIVE;
        end
        else if (busReqPending_ff && (busReqKind_ff == `PLRS_REQ_IMM || arbitrationWon))
        begin
          nxtState   = PLRS_IF_GRANT;
          grantTaken = 1'b1;
        end
        else if ((flag_ff != '0) || bufOutValid)
        begin
          nxtState = PLRS_IF_STATUS;
          nxtCnt   = '0;
          nxtLong  = bufOutValid;
        end
      end
      PLRS_IF_STATUS:
      begin
        if (packetReceiveActive)
        begin
          nxtState = PLRS_IF_RECEIVE;
        end
        else if (stCnt_ff == (stLong_ff ? `PLRS_ST_LAST_LONG : `PLRS_ST_LAST_SHORT))
        begin
          nxtState     = PLRS_IF_IDLE;
          regDelivered = stLong_ff;
        end
        else
        begin
          nxtCnt = stCnt_ff + 1'b1;
        end
      end
      PLRS_IF_RECEIVE:
      begin
        if (!packetReceiveActive)
        begin
          if (busReqPending_ff && (busReqKind_ff == `PLRS_REQ_IMM))
          begin
            nxtState   = PLRS_IF_GRANT;
            grantTaken = 1'b1;
          end
          else
          begin
            nxtState = PLRS_IF_IDLE;
          end
        end
      end
      PLRS_IF_GRANT:
      begin
        nxtState = PLRS_IF_LINK;
      end
      PLRS_IF_LINK:
      begin
        // The link may release straight away after a bad header.
        if (controlPairIn == `PLRS_LNK_RELEASE)
        begin
          nxtState = PLRS_IF_IDLE;
        end
      end
      default:
      begin
        nxtState = PLRS_IF_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff  <= PLRS_IF_IDLE;
      stCnt_ff  <= '0;
      stLong_ff <= 1'b0;
    end
    else
    begin
      state_ff  <= nxtState;
      stCnt_ff  <= nxtCnt;
      stLong_ff <= nxtLong;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      controlPairOut_ff <= `PLRS_CTL_IDLE;
      controlPairOe_ff  <= 1'b1;
      statusDataOut_ff  <= '0;
      statusDataOe_ff   <= 1'b0;
    end
    else
    begin
      controlPairOut_ff <= ctlCode(nxtState);
      controlPairOe_ff  <= (nxtState != PLRS_IF_LINK);
      statusDataOe_ff   <= (nxtState == PLRS_IF_STATUS);
      if (nxtState == PLRS_IF_STATUS)
      begin
        statusDataOut_ff <= {stWord[15 - 2 * nxtCnt], stWord[14 - 2 * nxtCnt]};
      end
      else
      begin
        statusDataOut_ff <= '0;
      end
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign controlPairOut    = controlPairOut_ff;
  assign controlPairOe     = controlPairOe_ff;
  assign statusDataOut     = statusDataOut_ff;
  assign statusDataOe      = statusDataOe_ff;
  assign busRequestPending = busReqPending_ff;
  assign busRequestKind    = busReqKind_ff;
  assign busRequestSpeed   = busReqSpeed_ff;
  assign accelFeaturesOn   = accelFeaturesOn_ff;
  assign regWriteStrobe    = regWriteStrobe_ff;
  assign regWriteAddr      = regWriteAddr_ff;
  assign regWriteData      = regWriteData_ff;
  assign readPending       = readPending_ff;

endmodule

// file: verification/plrs_link_model.sv
/* Link controller model: sends request streams MSB first and hands the control pair back after a grant.
   Assumes the bench clock and a request word left-aligned in reqWord. */
`timescale 1ns/1ps
module plrs_link_model
  import plrs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reqGo,
  input  wire logic [16:0] reqWord,
  input  wire logic [4:0]  reqLen,
  input  wire logic [1:0]  controlPairOut,
  input  wire logic        controlPairOe,
  output logic             linkRequestLine,
  output logic             reqBusy,
  output logic      [1:0]  controlPairIn
);
  logic [16:0] shift_ff;
  logic [4:0]  count_ff = 5'h0;
  logic [1:0]  hold_ff = 2'h0;
  always_ff @(posedge ref_clk)
  begin
    if (reqGo)
      {shift_ff, count_ff} <= {reqWord, reqLen};
    else if (reqBusy)
      {shift_ff, count_ff} <= {shift_ff << 1, count_ff - 5'h1};
  end
  // Holds the pair for two cycles before releasing it.
  always_ff @(posedge ref_clk)
    hold_ff <= controlPairOe ? 2'h2 : hold_ff - {1'b0, hold_ff != 2'h0};
  assign reqBusy = count_ff != 5'h0;
  assign linkRequestLine = reqBusy & shift_ff[16];
  assign controlPairIn = controlPairOe ? controlPairOut : {1'b0, hold_ff != 2'h0};
endmodule

// file: verification/plrs_top_chk.sv
/* Port timing checker for plrs_top.
   Assumes it is bound to plrs_top. */
`timescale 1ns/1ps
module plrs_top_chk
  import plrs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       packetReceiveActive,
  input wire logic       arbitrationWon,
  input wire logic       busResetEvent,
  input wire logic [1:0] controlPairOut,
  input wire logic       controlPairOe,
  input wire logic       statusDataOe,
  input wire logic       busRequestPending,
  input wire logic [2:0] busRequestKind,
  input wire logic       accelFeaturesOn,
  input wire logic       regWriteStrobe,
  input wire logic [3:0] regWriteAddr,
  input wire logic [7:0] regWriteData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence sShort; statusDataOe [*2] ##1 !statusDataOe; endsequence
  sequence sLong; statusDataOe [*8] ##1 !statusDataOe; endsequence
  a_status_code: assert property (statusDataOe |-> controlPairOe && controlPairOut == 2'h1)
    else $error("status code missing");
  a_status_len: assert property ($rose(statusDataOe) |->
    sShort or sLong or (##[1:8] (controlPairOut == 2'h2))) else $error("status length");
  a_idle_gap: assert property (statusDataOe ##1 !statusDataOe |=> !statusDataOe)
    else $error("no idle gap");
  a_recv_drop: assert property (controlPairOut == 2'h2 |=>
    !(busRequestPending && busRequestKind[2:1] == 2'h1)) else $error("fair kept in receive");
  a_reset_clear: assert property (busResetEvent |=> !busRequestPending)
    else $error("request kept on reset");
  a_iso_hold: assert property (busRequestPending && busRequestKind == 3'h1 && !arbitrationWon
    && !$past(arbitrationWon) && !busResetEvent |=> busRequestPending) else $error("iso dropped");
  a_grant_ack: assert property ($fell(packetReceiveActive) && busRequestPending && busRequestKind == 3'h0
    |-> ##[0:2] (controlPairOut == 2'h3)) else $error("no grant");
  a_accel_off: assert property (regWriteStrobe && regWriteAddr == 4'h5 && !regWriteData[1]
    |=> !accelFeaturesOn) else $error("accel on");
endmodule
bind plrs_top plrs_top_chk i_plrs_top_chk (.ref_clk, .rst, .packetReceiveActive, .arbitrationWon, .busResetEvent,
  .controlPairOut, .controlPairOe, .statusDataOe, .busRequestPending, .busRequestKind, .accelFeaturesOn,
  .regWriteStrobe, .regWriteAddr, .regWriteData);

// file: verification/plrs_top_test.sv
/* Self-checking bench for plrs_top.
   Assumes the link model and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin nMismatch++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module plrs_top_test
  import plrs_pkg::*;
;
  logic        ref_clk = 1'b0, rst = 1'b1, reqGo = 1'b0, packetReceiveActive = 1'b0;
  logic        arbitrationWon = 1'b0, busResetEvent = 1'b0, selfIdComplete = 1'b0;
  logic        linkRequestLine, reqBusy, controlPairOe, statusDataOe, busRequestPending, accelFeaturesOn;
  logic        regWriteStrobe, readPending;
  logic [16:0] reqWord = 17'h0;
  logic [4:0]  reqLen = 5'h0;
  logic [1:0]  controlPairIn, controlPairOut, statusDataOut;
  logic [2:0]  busRequestKind, busRequestSpeed;
  logic [3:0]  regWriteAddr;
  logic [7:0]  regWriteData;
  logic [15:0] st = 16'h0;
  // Each row: expected accel state, register address, data.
  logic [12:0] rows [4] = '{13'h005a, 13'h0fa5, 13'h1502, 13'h05fd};
  int          nMismatch = 0, checksDone = 0, cyc = 0;
  plrs_top i_plrs_top (.ref_clk, .rst, .linkRequestLine, .controlPairIn, .controlPairOut, .controlPairOe,
    .statusDataOut, .statusDataOe, .packetReceiveActive, .arbitrationWon, .arbResetGapEvent(1'b0),
    .subactionGapEvent(1'b0), .busResetEvent, .interruptEvent(1'b0), .selfIdComplete, .busRequestPending,
    .busRequestKind, .busRequestSpeed, .accelFeaturesOn, .regWriteStrobe, .regWriteAddr, .regWriteData,
    .readPending);
  plrs_link_model i_plrs_link_model (.ref_clk, .reqGo, .reqWord, .reqLen, .controlPairOut, .controlPairOe,
    .linkRequestLine, .reqBusy, .controlPairIn);
  always #25 ref_clk = ~ref_clk;
  task automatic stop_test();
    if (nMismatch == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (++cyc == 3000)
    begin
      nMismatch++;
      stop_test();
    end
  task automatic send(input logic [16:0] w, input logic [4:0] n);
    @(negedge ref_clk) {reqGo, reqWord, reqLen} = {1'b1, w, n};
    @(negedge ref_clk) reqGo = 1'b0;
    for (int i = 0; i < 30 && reqBusy; i++) @(negedge ref_clk);
  endtask
  task automatic getSt(input int n);
    for (int i = 0; i < 40 && statusDataOe !== 1'b1; i++) @(negedge ref_clk);
    repeat (n)
    begin
      st = {st[13:0], statusDataOut};
      @(negedge ref_clk);
    end
  endtask
  // Waits for the interface to be idle, so bus requests start after it.
  task automatic waitIdle();
    for (int i = 0; i < 20 && {controlPairOe, controlPairOut} !== 3'h4; i++) @(negedge ref_clk);
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    `CHK({controlPairOe, controlPairOut, accelFeaturesOn}, 4'h8)
    foreach (rows[k])
    begin
      send({4'hd, rows[k][11:0], 1'b0}, 5'h11);
      `CHK({regWriteStrobe, regWriteAddr, regWriteData}, {1'b1, rows[k][11:0]})
      repeat (2) @(negedge ref_clk);
      `CHK(accelFeaturesOn, rows[k][12])
      send({4'hc, rows[k][11:8], 9'h0}, 5'h9);
      `CHK(readPending, 1'b1)
      getSt(8);
      `CHK(st, {4'h0, rows[k][11:0]})
      `CHK(readPending, 1'b0)
    end
    send({4'hd, 12'h502, 1'b0}, 5'h11);
    send({4'he, 13'h0}, 5'h6);
    repeat (2) @(negedge ref_clk);
    `CHK(accelFeaturesOn, 1'b0)
    waitIdle();
    send({4'hb, 13'h0}, 5'h7);
    send({4'h9, 13'h0}, 5'h7);
    `CHK({busRequestPending, busRequestKind}, 4'hb)
    busResetEvent = 1'b1;
    @(negedge ref_clk) busResetEvent = 1'b0;
    `CHK(busRequestPending, 1'b0)
    getSt(2);
    `CHK({st[3:0], accelFeaturesOn}, 5'h05)
    // Self-identity status cut by a packet after three cycles must come back whole.
    selfIdComplete = 1'b1;
    @(negedge ref_clk) selfIdComplete = 1'b0;
    getSt(2);
    packetReceiveActive = 1'b1;
    @(negedge ref_clk) packetReceiveActive = 1'b0;
    getSt(8);
    `CHK(st, 16'h005a)
    waitIdle();
    send({4'hb, 13'h0}, 5'h7);
    packetReceiveActive = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK({controlPairOut, busRequestPending}, 3'h4)
    send({4'hb, 13'h0}, 5'h7);
    `CHK(busRequestPending, 1'b0)
    send({4'h8, 3'h4, 10'h0}, 5'h7);
    `CHK(busRequestPending, 1'b1)
    `CHK(busRequestSpeed, 3'h4)
    packetReceiveActive = 1'b0;
    for (int i = 0; i < 5 && controlPairOut !== 2'h3; i++) @(negedge ref_clk);
    `CHK({controlPairOut, busRequestPending}, 3'h6)
    waitIdle();
    send({4'h9, 13'h0}, 5'h7);
    packetReceiveActive = 1'b1;
    repeat (2) @(negedge ref_clk) packetReceiveActive = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(busRequestPending, 1'b1)
    arbitrationWon = 1'b1;
    @(negedge ref_clk) arbitrationWon = 1'b0;
    for (int i = 0; i < 5 && controlPairOut !== 2'h3; i++) @(negedge ref_clk);
    `CHK({controlPairOut, busRequestPending}, 3'h6)
    stop_test();
  end
endmodule
